// File: verilog/dap_pkg.sv
// Package for the dual analog-shared I/O port block.
// Assumes an AXI4-Lite master with 32-bit data reaches the registers.
package dap_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DAP_PA_LATCH_OFS = 8'h00;
    localparam logic [7:0] DAP_PA_DIR_OFS = 8'h04;
    localparam logic [7:0] DAP_PA_INEN_OFS = 8'h08;
    localparam logic [7:0] DAP_WAKE_EN_OFS = 8'h0C;
    localparam logic [7:0] DAP_PB_LATCH_OFS = 8'h10;
    localparam logic [7:0] DAP_PB_DIR_OFS = 8'h14;
    localparam logic [7:0] DAP_PB_INEN_OFS = 8'h18;

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam int DAP_PORT_W = 8;
    localparam int DAP_WAKE_W = 4;
    localparam logic [7:0] DAP_LATCH_RST = 8'h00;
    localparam logic [7:0] DAP_DIR_RST = 8'h00;
    localparam logic [7:0] DAP_INEN_RST = 8'hFF;
    localparam logic [3:0] DAP_WAKE_RST = 4'h0;
    localparam logic [1:0] DAP_RESP_OKAY = 2'b00;
    localparam logic [1:0] DAP_RESP_SLVERR = 2'b10;

    // Pin-side bundle for one 8-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dap_pin_drv_t;

endpackage

// File: verilog/dap_port.sv
// Two 8-bit general-purpose ports sharing pins with the converter input mux.
// Assumes pins are asynchronous; converter select arrives from on-chip logic.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module dap_port
    import dap_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [7:0] port_a_pin_in,
    output dap_pin_drv_t port_a_pin,
    input wire logic [7:0] port_b_pin_in,
    output dap_pin_drv_t port_b_pin,
    // Converter input select: one-hot over 16 pins, A in [7:0]
    input wire logic [15:0] converter_input_select,
    output logic [15:0] analog_connect,
    // Alternate digital functions
    output logic [3:0] key_wakeup_a,
    output logic [7:0] port_b_alt_in
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] sync1_reg, sync1_next;
    logic [15:0] sync2_reg, sync2_next;

    // Two stages; only sync2 is read by logic
    always_comb begin
        sync1_next = {port_b_pin_in, port_a_pin_in};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // ------------------------------------------------------------
    // Control registers and AXI4-Lite slave
    // ------------------------------------------------------------
    logic [7:0] port_a_output_latch_reg, port_a_output_latch_next;
    logic [7:0] port_a_direction_ctrl_reg, port_a_direction_ctrl_next;
    logic [7:0] port_a_input_enable_reg, port_a_input_enable_next;
    logic [3:0] key_wakeup_enable_reg, key_wakeup_enable_next;
    logic [7:0] port_b_output_latch_reg, port_b_output_latch_next;
    logic [7:0] port_b_direction_ctrl_reg, port_b_direction_ctrl_next;
    logic [7:0] port_b_input_enable_reg, port_b_input_enable_next;
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic arready_reg, arready_next;
    logic [7:0] port_a_read, port_b_read;

    // Read-back view per bit; the readback mirrors the pin on inputs with input enable set, which
    // is why a read-modify-write can clobber input latches
    always_comb begin
        for (int i = 0; i < DAP_PORT_W; i++) begin
            port_a_read[i] = port_a_direction_ctrl_reg[i] ? port_a_output_latch_reg[i]
                : (port_a_input_enable_reg[i] & sync2_reg[i]);
            port_b_read[i] = port_b_direction_ctrl_reg[i] ? port_b_output_latch_reg[i]
                : (port_b_input_enable_reg[i] & sync2_reg[i+8]);
        end
    end

    // Write path: address and data taken in either order, one at a time
    always_comb begin
        logic do_wr;
        do_wr = 1'b0;
        port_a_output_latch_next = port_a_output_latch_reg;
        port_a_direction_ctrl_next = port_a_direction_ctrl_reg;
        port_a_input_enable_next = port_a_input_enable_reg;
        key_wakeup_enable_next = key_wakeup_enable_reg;
        port_b_output_latch_next = port_b_output_latch_reg;
        port_b_direction_ctrl_next = port_b_direction_ctrl_reg;
        port_b_input_enable_next = port_b_input_enable_reg;
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && !aw_held_reg && !bvalid_reg) begin
            aw_held_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_reg && !bvalid_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata[7:0];
            wstrb0_next = s_axi_wstrb[0];
        end
        if (aw_held_reg && w_held_reg) begin
            do_wr = 1'b1;
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = DAP_RESP_OKAY;
        end
        // Only byte lane 0 carries data; other lanes are ignored
        if (do_wr && wstrb0_reg) begin
            unique case (awaddr_reg)
                DAP_PA_LATCH_OFS: port_a_output_latch_next = wdata_reg;
                DAP_PA_DIR_OFS: port_a_direction_ctrl_next = wdata_reg;
                DAP_PA_INEN_OFS: port_a_input_enable_next = wdata_reg;
                DAP_WAKE_EN_OFS: key_wakeup_enable_next = wdata_reg[3:0];
                DAP_PB_LATCH_OFS: port_b_output_latch_next = wdata_reg;
                DAP_PB_DIR_OFS: port_b_direction_ctrl_next = wdata_reg;
                DAP_PB_INEN_OFS: port_b_input_enable_next = wdata_reg;
                default: bresp_next = DAP_RESP_SLVERR;
            endcase
        end else if (do_wr) begin
            unique case (awaddr_reg)
                DAP_PA_LATCH_OFS, DAP_PA_DIR_OFS, DAP_PA_INEN_OFS, DAP_WAKE_EN_OFS,
                DAP_PB_LATCH_OFS, DAP_PB_DIR_OFS, DAP_PB_INEN_OFS: bresp_next = DAP_RESP_OKAY;
                default: bresp_next = DAP_RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // Read path: one read in flight, answer the cycle after the address
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = DAP_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            unique case (s_axi_araddr)
                DAP_PA_LATCH_OFS: rdata_next[7:0] = port_a_read;
                DAP_PA_DIR_OFS: rdata_next[7:0] = port_a_direction_ctrl_reg;
                DAP_PA_INEN_OFS: rdata_next[7:0] = port_a_input_enable_reg;
                DAP_WAKE_EN_OFS: rdata_next[3:0] = key_wakeup_enable_reg;
                DAP_PB_LATCH_OFS: rdata_next[7:0] = port_b_read;
                DAP_PB_DIR_OFS: rdata_next[7:0] = port_b_direction_ctrl_reg;
                DAP_PB_INEN_OFS: rdata_next[7:0] = port_b_input_enable_reg;
                default: rresp_next = DAP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            port_a_output_latch_reg <= DAP_LATCH_RST;
            port_a_direction_ctrl_reg <= DAP_DIR_RST;
            port_a_input_enable_reg <= DAP_INEN_RST;
            key_wakeup_enable_reg <= DAP_WAKE_RST;
            port_b_output_latch_reg <= DAP_LATCH_RST;
            port_b_direction_ctrl_reg <= DAP_DIR_RST;
            port_b_input_enable_reg <= DAP_INEN_RST;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= DAP_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= DAP_RESP_OKAY;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
        end else begin
            port_a_output_latch_reg <= port_a_output_latch_next;
            port_a_direction_ctrl_reg <= port_a_direction_ctrl_next;
            port_a_input_enable_reg <= port_a_input_enable_next;
            key_wakeup_enable_reg <= key_wakeup_enable_next;
            port_b_output_latch_reg <= port_b_output_latch_next;
            port_b_direction_ctrl_reg <= port_b_direction_ctrl_next;
            port_b_input_enable_reg <= port_b_input_enable_next;
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
        end
    end

    // Ready is high while the channel has room to take an item; built from
    // the next state so the flop matches the held and answer flags exactly
    always_comb begin
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ------------------------------------------------------------
    // Pin drive, analog routing and alternate inputs
    // ------------------------------------------------------------
    dap_pin_drv_t pa_reg, pa_next, pb_reg, pb_next;
    logic [15:0] analog_reg, analog_next;
    logic [3:0] wake_reg, wake_next;
    logic [7:0] pb_alt_reg, pb_alt_next;

    // Registered so every output leaves a flip-flop; one cycle of lag
    always_comb begin
        pa_next.out = port_a_output_latch_reg;
        pa_next.oe = port_a_direction_ctrl_reg;
        pb_next.out = port_b_output_latch_reg;
        pb_next.oe = port_b_direction_ctrl_reg;
        // Switch only for a selected pin that is not driving; guards
        analog_next = converter_input_select
            & ~{port_b_direction_ctrl_reg, port_a_direction_ctrl_reg};
        // Wakeup ignores input enable on port A low pins
        wake_next = key_wakeup_enable_reg & ~port_a_direction_ctrl_reg[3:0]
            & sync2_reg[3:0];
        pb_alt_next = ~port_b_direction_ctrl_reg & port_b_input_enable_reg
            & sync2_reg[15:8];
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pa_reg <= '0;
            pb_reg <= '0;
            analog_reg <= 16'h0000;
            wake_reg <= 4'h0;
            pb_alt_reg <= 8'h00;
        end else begin
            pa_reg <= pa_next;
            pb_reg <= pb_next;
            analog_reg <= analog_next;
            wake_reg <= wake_next;
            pb_alt_reg <= pb_alt_next;
        end
    end

    assign port_a_pin = pa_reg;
    assign port_b_pin = pb_reg;
    assign analog_connect = analog_reg;
    assign key_wakeup_a = wake_reg;
    assign port_b_alt_in = pb_alt_reg;

endmodule

// File: tb/dap_pin_model.sv
// Pin-side partner: resolves each pad from the block's drive and the outside world.
// Assumes the bench supplies the level that external circuitry puts on undriven pads.
`timescale 1ns/100ps
module dap_pin_model
    import dap_pkg::*;
(
    input wire logic [7:0] ext_level,
    input wire dap_pin_drv_t pin,
    output logic [7:0] pin_in
);
    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    // Driven pads follow the latch, others the outside source
    assign pin_in = (pin.oe & pin.out) | (~pin.oe & ext_level);
endmodule

// File: tb/dap_port_chk.sv
// Checker: bus handshakes and pin-side relations of the port block.
// Assumes it is bound to dap_port and sees only that module's ports.
`timescale 1ns/100ps
module dap_port_chk
    import dap_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dap_pin_drv_t port_a_pin,
    input wire dap_pin_drv_t port_b_pin,
    input wire logic [15:0] converter_input_select,
    input wire logic [15:0] analog_connect
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Reset leaves every pad undriven and the bus idle
    property p_reset_idle;
        $rose(resetn) |-> port_a_pin.oe == 8'h00 && port_b_pin.oe == 8'h00
            && analog_connect == 16'h0000 && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pads or bus busy after reset");
    property p_write_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_write_lat: assert property (p_write_lat) else $error("write response out of time");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response not retired");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
    property p_read_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer late");
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("read answer not retired");
    property p_ar_block;
        s_axi_arready == !s_axi_rvalid;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read ready wrong");
    // Offsets past the last register must be refused
    property p_slverr_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
            |=> s_axi_rresp == DAP_RESP_SLVERR;
    endproperty
    a_slverr_rd: assert property (p_slverr_rd) else $error("unmapped read not refused");
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_analog_sel;
        (analog_connect & ~$past(converter_input_select)) == 16'h0000;
    endproperty
    a_analog_sel: assert property (p_analog_sel) else $error("unselected pad on converter");

    // Main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_refuse: cover property (s_axi_rvalid && s_axi_rresp == DAP_RESP_SLVERR);
    c_analog: cover property (analog_connect != 16'h0000);
endmodule

bind dap_port dap_port_chk dap_port_chk_inst (
    .clock(clock), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_a_pin(port_a_pin), .port_b_pin(port_b_pin),
    .converter_input_select(converter_input_select), .analog_connect(analog_connect)
);

// File: tb/tb.sv
// Testbench: register accesses over the bus, pad levels through the partner model.
// Assumes the package constants; waits on the slave's own answers, no fixed latency.
`timescale 1ns/100ps
module tb
    import dap_pkg::*;
;
    logic clock;
    logic resetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ext_a, ext_b, port_a_pin_in, port_b_pin_in;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, key_wakeup_a;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] port_b_alt_in;
    logic [15:0] converter_input_select, analog_connect;
    dap_pin_drv_t port_a_pin, port_b_pin;
    int fails, comparisons;
    // Reset read-back of the seven offsets, pads idle at A5 and 3C
    logic [31:0] rst_exp [7] = '{32'hA5, 32'h00, 32'hFF, 32'h00, 32'h3C, 32'h00, 32'hFF};

    dap_port dap_port_inst (
        .clock(clock), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .port_a_pin_in(port_a_pin_in), .port_a_pin(port_a_pin),
        .port_b_pin_in(port_b_pin_in), .port_b_pin(port_b_pin),
        .converter_input_select(converter_input_select), .analog_connect(analog_connect),
        .key_wakeup_a(key_wakeup_a), .port_b_alt_in(port_b_alt_in)
    );
    dap_pin_model pads_a (.ext_level(ext_a), .pin(port_a_pin), .pin_in(port_a_pin_in));
    dap_pin_model pads_b (.ext_level(ext_b), .pin(port_b_pin), .pin_in(port_b_pin_in));

    // ------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Each channel released at its own handshake edge; only the watchdog ends a hang
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        check(s_axi_bresp, r);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a, input logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        check(s_axi_rresp, r);
        s_axi_rready <= 1'b0;
    endtask
    task automatic done(input string s);
        $display("test %s finished, fails so far %0d", s, fails);
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        ext_a = 8'hA5;
        ext_b = 8'h3C;
        converter_input_select = 16'h0000;
        fails = 0;
        comparisons = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        // Pad synchronisers restart at zero; let them fill before reading pins
        repeat (2) @(posedge clock);
        for (int i = 0; i < 7; i++) begin
            rdb(8'(i * 4), DAP_RESP_OKAY);
            check(rd, rst_exp[i]);
        end
        check(port_a_pin.oe, 8'h00);
        done("reset");
        // Mixed A: 0,1,4,5 out; 6,7 digital in; 2,3 analog
        wr(DAP_PA_LATCH_OFS, 32'h0F, 4'hF, DAP_RESP_OKAY);
        wr(DAP_PA_DIR_OFS, 32'h33, 4'hF, DAP_RESP_OKAY);
        wr(DAP_PA_INEN_OFS, 32'hF0, 4'hF, DAP_RESP_OKAY);
        wr(DAP_WAKE_EN_OFS, 32'h0C, 4'hF, DAP_RESP_OKAY);
        repeat (4) @(posedge clock);
        check(port_a_pin.oe, 8'h33);
        check(port_a_pin.out & 8'h33, 8'h03);
        rdb(DAP_PA_LATCH_OFS, DAP_RESP_OKAY);
        check(rd, 32'h83);
        rdb(DAP_WAKE_EN_OFS, DAP_RESP_OKAY);
        check(rd, 32'h0C);
        check(key_wakeup_a, 4'h4);
        done("port_a");
        wr(DAP_PB_LATCH_OFS, 32'hFF, 4'hF, DAP_RESP_OKAY);
        wr(DAP_PB_DIR_OFS, 32'hF0, 4'hF, DAP_RESP_OKAY);
        wr(DAP_PB_INEN_OFS, 32'h0F, 4'hF, DAP_RESP_OKAY);
        repeat (4) @(posedge clock);
        check(port_b_pin.oe & port_b_pin.out, 8'hF0);
        rdb(DAP_PB_LATCH_OFS, DAP_RESP_OKAY);
        check(rd, 32'hFC);
        check(port_b_alt_in, 8'h0C);
        done("port_b");
        // Latches left alone while the converter samples
        converter_input_select <= 16'h0004;
        repeat (3) @(posedge clock);
        check(analog_connect, 16'h0004);
        rdb(DAP_PA_LATCH_OFS, DAP_RESP_OKAY);
        check(rd, 32'h83);
        converter_input_select <= 16'h0000;
        repeat (3) @(posedge clock);
        check(analog_connect, 16'h0000);
        done("analog");
        wr(8'h1C, 32'hFF, 4'hF, DAP_RESP_SLVERR);
        rdb(8'h1C, DAP_RESP_SLVERR);
        wr(DAP_PA_LATCH_OFS, 32'hFF, 4'h0, DAP_RESP_OKAY);
        rdb(DAP_PA_LATCH_OFS, DAP_RESP_OKAY);
        check(rd, 32'h83);
        done("refused");
        // Read-modify-write copies pad levels into input latches
        wr(DAP_PA_LATCH_OFS, rd | 32'h10, 4'hF, DAP_RESP_OKAY);
        wr(DAP_PA_DIR_OFS, 32'hFF, 4'hF, DAP_RESP_OKAY);
        repeat (4) @(posedge clock);
        rdb(DAP_PA_LATCH_OFS, DAP_RESP_OKAY);
        check(rd, 32'h93);
        check(port_a_pin.out, 8'h93);
        done("rmw");
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rdb(DAP_PA_DIR_OFS, DAP_RESP_OKAY);
        check(rd, 32'h00);
        check(port_a_pin.oe, 8'h00);
        done("second_reset");
        print_verdict();
    end
endmodule
